//--- sdm_error_monitor.v
// Purpose: status and error monitor register group of a serial video
//   deserializer, reached over the management port register access
// Assumes: reg_wr/reg_rd are one-cycle strobes from the management slave
// Notes: read data is registered, valid the cycle after reg_rd
// Function
// - select bit picks counter; enable gates counting
// - writing one clears clock-recovery event count
// - writing one clears data event counter
// - accumulate keeps adding to error count
// - code-error disable masks count and lock
// - clear zeroes current and held counts
// - display bit picks run or window count
// - hold bit keeps normal state past threshold
// - 16-bit threshold, defaults 0x10 and 0x00
// - above threshold, stop accepting and forwarding data
// - rate field bits 6:4, 111 unlocked
// - eight-bit count of selected clock-recovery or link-loss events
// - data error count low and high bytes
`timescale 1ns/10ps
`default_nettype none
`include "sdm_consts.vh"

module sdm_error_monitor
(
    input wire clk,
    input wire rst_b,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    input wire cdr_locked,
    input wire [1:0] cdr_rate_sel,
    input wire clk_loss,
    input wire sig_det_ch0,
    input wire sig_det_ch1,
    input wire data_err,
    input wire code_err,
    input wire window_end,
    input wire link_lost,
    input wire [4:0] rx_data,
    output reg [4:0] parallel_output_pins_ff,
    output wire lock_out,
    output wire data_accept
);

    // ======================================================================
    // control registers
    reg [3:0] evt_cfg_ff;
    reg [4:0] mon_ctl_ff;
    reg [7:0] thr_lo_ff;
    reg [7:0] thr_hi_ff;
    reg [15:0] run_cnt_ff;
    reg [15:0] win_cnt_ff;
    reg stopped_ff;
    reg clk_loss_d_ff;
    reg lock_d_ff;
    reg link_lost_d_ff;

    wire wr_evt = reg_wr && reg_addr == `SDM_ADDR_EVT_CFG;
    wire wr_mon = reg_wr && reg_addr == `SDM_ADDR_MON_CTL;
    wire evt_en = evt_cfg_ff[`SDM_EVT_EN];
    wire code_dis = mon_ctl_ff[`SDM_MON_CODE_DIS];
    wire hold = mon_ctl_ff[`SDM_MON_HOLD];
    wire [15:0] thr = {thr_hi_ff, thr_lo_ff};

    // reset bits self-clear so a second write of one clears again
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evt_cfg_ff <= 4'h0;
            mon_ctl_ff <= 5'h00;
            thr_lo_ff <= `SDM_RST_THR_LO;
            thr_hi_ff <= `SDM_RST_THR_HI;
        end
        else
        begin
            if (wr_evt)
                evt_cfg_ff <= reg_wdata[3:0];
            else
                evt_cfg_ff[2:1] <= 2'h0;
            if (wr_mon)
                mon_ctl_ff <= reg_wdata[4:0];
            else
                mon_ctl_ff[`SDM_MON_CLEAR] <= 1'b0;
            if (reg_wr && reg_addr == `SDM_ADDR_THR_LO)
                thr_lo_ff <= reg_wdata;
            if (reg_wr && reg_addr == `SDM_ADDR_THR_HI)
                thr_hi_ff <= reg_wdata;
        end
    end

    wire clr_cdr = wr_evt && reg_wdata[`SDM_EVT_RST_CDR];
    wire clr_link = wr_evt && reg_wdata[`SDM_EVT_RST_LINK];
    wire clr_mon = wr_mon && reg_wdata[`SDM_MON_CLEAR];

    // ======================================================================
    // event edges
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clk_loss_d_ff <= 1'b0;
            lock_d_ff <= 1'b0;
            link_lost_d_ff <= 1'b0;
        end
        else
        begin
            clk_loss_d_ff <= clk_loss;
            lock_d_ff <= cdr_locked;
            link_lost_d_ff <= link_lost;
        end
    end

    wire cdr_evt = (clk_loss && !clk_loss_d_ff) || (lock_d_ff && !cdr_locked);
    wire link_evt = link_lost && !link_lost_d_ff;
    // code errors are masked from both the count and the lock output
    wire err_hit = data_err || (code_err && !code_dis);
    assign lock_out = cdr_locked && !(code_err && !code_dis);

    // ======================================================================
    // event counters
    wire [7:0] cdr_cnt;
    wire [7:0] link_cnt;
    wire [7:0] dsp_cnt;

    sdm_sat_cnt8 u_cdr_cnt
    (
        .clk(clk),
        .rst_b(rst_b),
        .clr(clr_cdr),
        .inc(evt_en && cdr_evt),
        .ld(1'b0),
        .ld_val(8'h00),
        .cnt_ff(cdr_cnt)
    );

    // the writable event count register loads the data counter directly
    sdm_sat_cnt8 u_link_cnt
    (
        .clk(clk),
        .rst_b(rst_b),
        .clr(clr_link),
        .inc(evt_en && link_evt),
        .ld(reg_wr && reg_addr == `SDM_ADDR_EVT_CNT),
        .ld_val(reg_wdata),
        .cnt_ff(link_cnt)
    );

    assign dsp_cnt = evt_cfg_ff[`SDM_EVT_SEL] ? link_cnt : cdr_cnt;

    // ======================================================================
    // error monitor counts
    // without accumulate the run count restarts at each window end;
    // the window count holds the total of the finished window
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_cnt_ff <= 16'h0000;
            win_cnt_ff <= 16'h0000;
        end
        else if (clr_mon)
        begin
            run_cnt_ff <= 16'h0000;
            win_cnt_ff <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == `SDM_ADDR_ERR_LO)
                run_cnt_ff[7:0] <= reg_wdata;
            else if (reg_wr && reg_addr == `SDM_ADDR_ERR_HI)
                run_cnt_ff[15:8] <= reg_wdata;
            else if (window_end && !mon_ctl_ff[`SDM_MON_ACCUM])
                run_cnt_ff <= {15'h0000, err_hit};
            else if (err_hit && run_cnt_ff != 16'hffff)
                run_cnt_ff <= run_cnt_ff + 16'h0001;
            if (window_end)
                win_cnt_ff <= run_cnt_ff;
        end
    end

    wire [15:0] err_dsp = mon_ctl_ff[`SDM_MON_DISP] ? win_cnt_ff
                                                    : run_cnt_ff;

    // ======================================================================
    // data stop above threshold
    // the stop is recomputed each cycle from count above threshold; hold forces it off
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            stopped_ff <= 1'b0;
        else if (hold)
            stopped_ff <= 1'b0;
        else
            stopped_ff <= run_cnt_ff > thr;
    end

    assign data_accept = !stopped_ff;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            parallel_output_pins_ff <= 5'h00;
        else if (!stopped_ff)
            parallel_output_pins_ff <= rx_data;
        else
            parallel_output_pins_ff <= 5'h00;
    end

    // ======================================================================
    // read mux
    wire [2:0] rate_code;

    sdm_rate_enc u_rate
    (
        .locked(cdr_locked),
        .rate_sel(cdr_rate_sel),
        .rate_code(rate_code)
    );

    reg [7:0] nxt_rdata;

    always @*
    begin
        case (reg_addr)
            `SDM_ADDR_EVT_CFG: nxt_rdata = {4'h0, evt_cfg_ff};
            `SDM_ADDR_MON_CTL: nxt_rdata = {3'h0, mon_ctl_ff};
            `SDM_ADDR_THR_LO: nxt_rdata = thr_lo_ff;
            `SDM_ADDR_THR_HI: nxt_rdata = thr_hi_ff;
            `SDM_ADDR_RATE: nxt_rdata = {1'b0, rate_code, 4'h0};
            `SDM_ADDR_LOCK: nxt_rdata = {4'h0, cdr_locked, sig_det_ch1,
                                         sig_det_ch0, 1'b0};
            `SDM_ADDR_EVT_CNT: nxt_rdata = dsp_cnt;
            `SDM_ADDR_ERR_LO: nxt_rdata = err_dsp[7:0];
            `SDM_ADDR_ERR_HI: nxt_rdata = err_dsp[15:8];
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata_ff <= 8'h00;
        else if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
    end

endmodule // sdm_error_monitor
`default_nettype wire

//--- sdm_consts.vh
// Purpose: constants for the deserializer error monitor register group
// Assumes: 8-bit registers at 8-bit offsets on the management port
// Notes: definitions only
`ifndef SDM_CONSTS_VH
`define SDM_CONSTS_VH

// ==========================================================================
// register offsets
`define SDM_ADDR_EVT_CFG 8'h2b
`define SDM_ADDR_MON_CTL 8'h2d
`define SDM_ADDR_THR_LO 8'h2e
`define SDM_ADDR_THR_HI 8'h2f
`define SDM_ADDR_RATE 8'h3b
`define SDM_ADDR_LOCK 8'h3c
`define SDM_ADDR_EVT_CNT 8'h3d
`define SDM_ADDR_ERR_LO 8'h3e
`define SDM_ADDR_ERR_HI 8'h3f

// ==========================================================================
// field positions
`define SDM_EVT_SEL 3
`define SDM_EVT_RST_CDR 2
`define SDM_EVT_RST_LINK 1
`define SDM_EVT_EN 0
`define SDM_MON_ACCUM 4
`define SDM_MON_CODE_DIS 3
`define SDM_MON_CLEAR 2
`define SDM_MON_DISP 1
`define SDM_MON_HOLD 0
`define SDM_LOCK_BIT 3
`define SDM_SIG1_BIT 2
`define SDM_SIG0_BIT 1

// ==========================================================================
// reset values and rate codes
`define SDM_RST_THR_LO 8'h10
`define SDM_RST_THR_HI 8'h00
`define SDM_RST_ZERO 8'h00
`define SDM_RATE_SD 3'h1
`define SDM_RATE_HD 3'h3
`define SDM_RATE_3G 3'h6
`define SDM_RATE_UNLOCKED 3'h7

`endif

//--- sdm_sat_cnt8.v
// Purpose: 8-bit saturating event counter with enable and clear
// Assumes: single clock, async active-low reset
// Notes: clear wins over count
`timescale 1ns/10ps
`default_nettype none
`include "sdm_consts.vh"

module sdm_sat_cnt8
(
    input wire clk,
    input wire rst_b,
    input wire clr,
    input wire inc,
    input wire ld,
    input wire [7:0] ld_val,
    output reg [7:0] cnt_ff
);
    // saturates so a long fault does not wrap back to a small count
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_ff <= `SDM_RST_ZERO;
        else if (clr)
            cnt_ff <= `SDM_RST_ZERO;
        else if (ld)
            cnt_ff <= ld_val;
        else if (inc && cnt_ff != 8'hff)
            cnt_ff <= cnt_ff + 8'h01;
    end
endmodule // sdm_sat_cnt8
`default_nettype wire

//--- sdm_rate_enc.v
// Purpose: encodes recovery lock and rate into the rate status field
// Assumes: rate_sel: 0 sd, 1 hd, 2 3g
// Notes: combinational
`timescale 1ns/10ps
`default_nettype none
`include "sdm_consts.vh"

module sdm_rate_enc
(
    input wire locked,
    input wire [1:0] rate_sel,
    output reg [2:0] rate_code
);
    always @*
    begin
        if (!locked)
            rate_code = `SDM_RATE_UNLOCKED;
        else
        begin
            case (rate_sel)
                2'h0: rate_code = `SDM_RATE_SD;
                2'h1: rate_code = `SDM_RATE_HD;
                2'h2: rate_code = `SDM_RATE_3G;
                default: rate_code = `SDM_RATE_UNLOCKED;
            endcase
        end
    end
endmodule // sdm_rate_enc
`default_nettype wire

//--- sdm_host_model.sv
// Purpose: management host model driving the register strobes
// Assumes: one transfer at a time, taken on the rising edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none

module sdm_host_model
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata_ff,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // ========
    // transfers
    initial reg_wr = 1'b0;
    initial reg_rd = 1'b0;
    initial reg_addr = 8'h00;
    initial reg_wdata = 8'h00;

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 v = reg_rdata_ff;
    endtask
endmodule // sdm_host_model
`default_nettype wire

//--- sdm_error_monitor_chk.sv
// Purpose: port assertions for the error monitor registers
// Assumes: read data follows the read strobe by one cycle
// Notes: bound to every instance of the design
`timescale 1ns/10ps
`default_nettype none

module sdm_error_monitor_chk
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic cdr_locked,
    input wire logic code_err,
    input wire logic [4:0] rx_data,
    input wire logic [4:0] parallel_output_pins_ff,
    input wire logic lock_out,
    input wire logic data_accept
);
    // ========
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_read_holds: assert property (
        !reg_rd |=> $stable(reg_rdata_ff)) else $error("read data moved");
    a_rate_field: assert property (
        reg_rd && reg_addr == 8'h3b |=> reg_rdata_ff[7] == 1'b0
        && reg_rdata_ff[3:0] == 4'h0) else $error("rate reserved bits");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr == 8'h2c |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    a_rst_selfclr: assert property (
        reg_wr && reg_addr == 8'h2b ##2 reg_rd && reg_addr == 8'h2b
        |=> reg_rdata_ff[2:1] == 2'b00) else $error("reset bits stuck");
    a_pins_follow: assert property (
        data_accept |=> parallel_output_pins_ff == $past(rx_data))
        else $error("accepted data lost");
    a_stop_zero: assert property (
        !data_accept |=> parallel_output_pins_ff == 5'h00)
        else $error("stopped data forwarded");
    a_lock_unlocked: assert property (
        !cdr_locked |-> !lock_out) else $error("lock while unlocked");
    a_lock_clean: assert property (
        cdr_locked && !code_err |-> lock_out) else $error("lock missing");
    c_stop: cover property ($fell(data_accept));
    c_rate: cover property (reg_rd && reg_addr == 8'h3b);
    c_masked: cover property (code_err && lock_out);
endmodule // sdm_error_monitor_chk

bind sdm_error_monitor sdm_error_monitor_chk u_sdm_error_monitor_chk (
    .clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_rdata_ff, .cdr_locked,
    .code_err, .rx_data, .parallel_output_pins_ff, .lock_out, .data_accept);
`default_nettype wire

//--- sdi_rx_error_monitor_regs_test.sv
// Purpose: self-checking bench for the error monitor registers
// Assumes: host model owns the register strobes
// Notes: tests share register state and run in order
`timescale 1ns/10ps
`default_nettype none

module sdi_rx_error_monitor_regs_test;
    // ========
    // harness
    logic clk = 1'b0, rst_b = 1'b0, cdr_locked = 1'b0, code_err = 1'b0;
    logic sig_det_ch0 = 1'b0, sig_det_ch1 = 1'b0;
    logic [1:0] cdr_rate_sel = 2'h0;
    logic [3:0] ev = 4'h0;
    logic [4:0] rx_data = 5'h15;
    wire logic reg_wr, reg_rd, lock_out, data_accept;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    wire logic [4:0] parallel_output_pins_ff;
    int err_total = 0, checks_done = 0;

    sdm_error_monitor u_sdm_error_monitor (.clk, .rst_b, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata_ff, .cdr_locked, .cdr_rate_sel,
        .clk_loss(ev[1]), .sig_det_ch0, .sig_det_ch1, .data_err(ev[0]),
        .code_err, .window_end(ev[3]), .link_lost(ev[2]), .rx_data,
        .parallel_output_pins_ff, .lock_out, .data_accept);
    sdm_host_model u_sdm_host_model (.clk, .reg_rdata_ff, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata);
    initial forever #20 clk = ~clk;

    // ========
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s exp %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, e);
        logic [7:0] v;
        u_sdm_host_model.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic wr(input logic [7:0] a, v);
        u_sdm_host_model.wr(a, v);
    endtask
    // bit 0 data error, 1 clock loss, 2 link loss, 3 window end
    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n)
        begin
            @(posedge clk) ev <= m;
            @(posedge clk) ev <= 4'h0;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========
    // tests
    task automatic t_defaults;
        rc(8'h2e, 8'h10);
        rc(8'h2f, 8'h00);
        rc(8'h3b, 8'h70);
        rc(8'h3d, 8'h00);
        rc(8'h3e, 8'h00);
        rc(8'h3f, 8'h00);
        rc(8'h2c, 8'h00);
        $display("defaults done");
    endtask
    task automatic t_events;
        wr(8'h2b, 8'h01);
        pulse(4'h2, 3);
        rc(8'h3d, 8'h03);
        wr(8'h2b, 8'h05);
        rc(8'h2b, 8'h01);
        rc(8'h3d, 8'h00);
        wr(8'h2b, 8'h08);
        pulse(4'h4, 2);
        rc(8'h3d, 8'h00);
        wr(8'h2b, 8'h09);
        pulse(4'h4, 2);
        rc(8'h3d, 8'h02);
        wr(8'h3d, 8'h05);
        rc(8'h3d, 8'h05);
        wr(8'h2b, 8'h0b);
        rc(8'h3d, 8'h00);
        wr(8'h2b, 8'h01);
        $display("events done");
    endtask
    task automatic t_status;
        logic [2:0] codes [4] = '{3'h1, 3'h3, 3'h6, 3'h7};
        @(posedge clk);
        cdr_locked <= 1'b1;
        sig_det_ch1 <= 1'b1;
        wr(8'h3b, 8'hff);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) cdr_rate_sel <= 2'(i);
            rc(8'h3b, {1'b0, codes[i], 4'h0});
        end
        rc(8'h3c, 8'h0c);
        @(posedge clk) code_err <= 1'b1;
        @(negedge clk);
        chk("lock_out", 8'h00, 8'(lock_out));
        wr(8'h2d, 8'h08);
        @(negedge clk);
        chk("lock_out", 8'h01, 8'(lock_out));
        @(posedge clk) code_err <= 1'b0;
        // two errors land before the mask takes hold, none after it
        rc(8'h3e, 8'h02);
        @(posedge clk) cdr_locked <= 1'b0;
        rc(8'h3d, 8'h01);
        $display("status done");
    endtask
    task automatic t_stop;
        wr(8'h2d, 8'h04);
        wr(8'h2e, 8'h03);
        pulse(4'h1, 3);
        @(negedge clk);
        chk("data_accept", 8'h01, 8'(data_accept));
        chk("pins", 8'h15, 8'(parallel_output_pins_ff));
        pulse(4'h1, 1);
        // the stop takes a few edges to reach the pins
        repeat (4) @(negedge clk);
        chk("data_accept", 8'h00, 8'(data_accept));
        chk("pins", 8'h00, 8'(parallel_output_pins_ff));
        rc(8'h3e, 8'h04);
        wr(8'h2d, 8'h01);
        repeat (4) @(negedge clk);
        chk("data_accept", 8'h01, 8'(data_accept));
        wr(8'h2d, 8'h04);
        rc(8'h3e, 8'h00);
        $display("stop done");
    endtask
    task automatic t_window;
        wr(8'h2d, 8'h00);
        pulse(4'h1, 2);
        pulse(4'h8, 1);
        rc(8'h3e, 8'h00);
        wr(8'h2d, 8'h02);
        rc(8'h3e, 8'h02);
        wr(8'h2d, 8'h10);
        pulse(4'h1, 2);
        pulse(4'h8, 1);
        rc(8'h3e, 8'h02);
        wr(8'h3f, 8'h01);
        rc(8'h3f, 8'h01);
        $display("window done");
    endtask
    // a mid-run reset must bring the defaults back and lift the stop
    task automatic t_reset;
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rc(8'h2e, 8'h10);
        rc(8'h3f, 8'h00);
        rc(8'h2d, 8'h00);
        chk("data_accept", 8'h01, 8'(data_accept));
        $display("reset done");
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_defaults;
        t_events;
        t_status;
        t_stop;
        t_window;
        t_reset;
        stop_test;
    end
    // the tests need well under a thousand cycles
    initial
    begin
        #100000;
        err_total++;
        stop_test;
    end
endmodule // sdi_rx_error_monitor_regs_test
`default_nettype wire
